// [dv/ksq_engine_model.sv]
/*
  Record engine model: takes offered record addresses oldest first
  and reports each one done a cycle after taking it.
  Assumes an offer stands until it is taken.
*/
`timescale 1ns/1ps
`default_nettype none
module ksq_engine_model (
  input  wire logic              clock,
  input  wire logic              rst,
  input  wire ksq_pkg::ksq_cmd_t cmd,
  input  wire logic              stall,
  output var  logic              cmd_take,
  output var  logic              cmd_done,
  output var  logic [31:0]       got0,
  output var  logic [31:0]       got1,
  output var  logic [3:0]        cnt
);
  import ksq_pkg::*;
  // Stall lets the bench fill both slots before anything drains
  always @(posedge clock) begin
    if (rst) begin
      cmd_take <= 1'b0;
      cmd_done <= 1'b0;
      cnt      <= 4'h0;
    end else begin
      cmd_take <= cmd.valid && !stall && !cmd_take;
      cmd_done <= cmd.valid && cmd_take;
      if (cmd.valid && cmd_take) begin
        if (cnt == 4'h0) got0 <= cmd.addr;
        if (cnt == 4'h1) got1 <= cmd.addr;
        cnt <= cnt + 4'h1;
      end
    end
  end
endmodule
`default_nettype wire

// [dv/test_ksq_top.sv]
/*
  Self-checking bench for the key-setup command queue.
  Assumes the register port and engine handshake of the design.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, gt) begin comparisons++; if ((gt) !== (ex)) begin \
  $display("BAD %s exp %h got %h", nm, ex, gt); bad_count++; end end
module test_ksq_top;
  import ksq_pkg::*;
  typedef struct {logic [7:0] a; logic [31:0] d; bit w; logic [31:0] m;} ksq_row_t;
  logic clock = 1'b0;
  logic rst = 1'b1;
  ksq_req_t req = '0;
  ksq_fault_t fault = '0;
  ksq_cmd_t cmd;
  logic [31:0] rdata, rdv, got0, got1;
  logic irq, cmd_take, cmd_done;
  logic stall = 1'b1;
  logic [3:0] cnt;
  int bad_count = 0;
  int comparisons = 0;
  ksq_row_t rows [10];
  logic [7:0] clr_off [2];
  always #25 clock = ~clock;
  ksq_top i_dut (.clock(clock), .rst(rst), .req(req), .rdata(rdata), .cmd(cmd),
    .cmd_take(cmd_take), .cmd_done(cmd_done), .fault(fault), .irq(irq));
  ksq_engine_model i_eng (.clock(clock), .rst(rst), .cmd(cmd), .stall(stall),
    .cmd_take(cmd_take), .cmd_done(cmd_done), .got0(got0), .got1(got1), .cnt(cnt));
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    req.addr <= a;
    req.wdata <= d;
    req.wr <= 1'b1;
    @(posedge clock);
    req.wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clock);
    req.addr <= a;
    req.rd <= 1'b1;
    @(posedge clock);
    req.rd <= 1'b0;
    @(negedge clock);
    rdv = rdata;
  endtask
  task automatic wait_cnt(input logic [3:0] n);
    for (int i = 0; i < 60 && cnt !== n; i++) @(posedge clock);
    repeat (3) @(posedge clock);
  endtask
  task automatic pulse_fault(input logic [29:0] wa, input logic isr);
    @(posedge clock);
    fault <= '{1'b1, wa, isr};
    @(posedge clock);
    fault.valid <= 1'b0;
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    #100000;
    bad_count++;
    complete_run;
  end
  initial begin
    // Engine stalled: two writes fill both slots, the third is dropped
    rows = '{'{8'h00, 32'h4, 1, 0}, '{8'h04, 0, 0, 32'hffff_ffff},
      '{8'h10, 32'h1000, 1, 0}, '{8'h10, 32'h1000, 0, 32'hffff_ffff},
      '{8'h10, 32'h2000, 1, 0}, '{8'h04, 32'h0800_0000, 0, 32'h1c00_0000},
      '{8'h10, 32'h3000, 1, 0}, '{8'h10, 32'h2000, 0, 32'hffff_ffff},
      '{8'h20, 0, 0, 32'hffff_ffff}, '{8'h04, 32'h0800_0000, 0, 32'h1c00_0000}};
    clr_off = '{8'h04, 8'h18};
    repeat (5) @(posedge clock);
    rst <= 1'b0;
    @(negedge clock);
    `CHK("irq", 1'b0, irq)
    `CHK("valid", 1'b0, cmd.valid)
    $display("test reset done");
    foreach (rows[i]) begin
      if (rows[i].w) wr(rows[i].a, rows[i].d);
      else begin
        rd(rows[i].a);
        `CHK("row", rows[i].d, rdv & rows[i].m)
      end
    end
    $display("test table done");
    `CHK("offer", 32'h1000, cmd.addr)
    stall <= 1'b0;
    wait_cnt(4'h2);
    `CHK("first", 32'h1000, got0)
    `CHK("second", 32'h2000, got1)
    rd(8'h04);
    `CHK("done", 32'h0400_0000, rdv & 32'h1c00_0000)
    `CHK("irq off", 1'b0, irq)
    wr(8'h14, 32'h0400_0000);
    for (int k = 0; k < 2; k++) begin
      if (k == 1) begin
        // Queue empty and mastering on: write, then read back with no gap
        @(posedge clock);
        req.addr  <= 8'h10;
        req.wdata <= 32'h4000;
        req.wr    <= 1'b1;
        @(posedge clock);
        req.wr <= 1'b0;
        req.rd <= 1'b1;
        @(posedge clock);
        req.rd <= 1'b0;
        @(negedge clock);
        `CHK("readback", 32'h4000, rdata)
        wait_cnt(4'h3);
      end
      // Interrupt output is registered behind the enable register
      repeat (2) @(negedge clock);
      `CHK("irq on", 1'b1, irq)
      wr(clr_off[k], 32'h0400_0000);
      rd(8'h04);
      `CHK("clear", 1'b0, rdv[26])
      `CHK("irq clr", 1'b0, irq)
    end
    $display("test done status done");
    pulse_fault(30'h0123_4567, 1'b1);
    rd(8'h0c);
    `CHK("fault rd", {30'h0123_4567, 1'b1}, rdv[31:1])
    pulse_fault(30'h0000_0abc, 1'b0);
    rd(8'h0c);
    `CHK("fault wr", {30'h0000_0abc, 1'b0}, rdv[31:1])
    // Error flag must survive a write of 1 and go on soft reset
    wr(8'h04, 32'h1000_0000);
    rd(8'h04);
    `CHK("err", 1'b1, rdv[28])
    wr(8'h00, 32'h8000_0000);
    rd(8'h04);
    `CHK("err sr", 1'b0, rdv[28])
    $display("test fault done");
    wr(8'h00, 32'h0);
    wr(8'h10, 32'h5000);
    repeat (4) @(posedge clock);
    @(negedge clock);
    `CHK("no master", 1'b0, cmd.valid)
    `CHK("no take", 4'h3, cnt)
    $display("test master off done");
    complete_run;
  end
endmodule
`default_nettype wire

// [src/ksq_pkg.sv]
/*
  Package for the key-setup command queue: register map, status and
  control bit positions, reset values and shared record types.
  Assumes a 32-bit register port with one-cycle read latency.
*/
package ksq_pkg;
  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] KSQ_OFF_CTRL    = 8'h00;
  localparam logic [7:0] KSQ_OFF_STATUS  = 8'h04;
  localparam logic [7:0] KSQ_OFF_FAULT   = 8'h0c;
  localparam logic [7:0] KSQ_OFF_CMD2    = 8'h10;
  localparam logic [7:0] KSQ_OFF_IRQ_EN  = 8'h14;
  localparam logic [7:0] KSQ_OFF_IRQ_CLR = 8'h18;
  // ----------------------------------------------------------------
  // Bit positions and slot count
  // ----------------------------------------------------------------
  localparam int KSQ_BIT_SOFT_RST  = 31;
  localparam int KSQ_BIT_MASTER_EN = 2;
  localparam int KSQ_BIT_ERR       = 28;
  localparam int KSQ_BIT_FULL      = 27;
  localparam int KSQ_BIT_DONE      = 26;
  localparam int KSQ_BIT_FAULT_RD  = 1;
  localparam int KSQ_SLOTS         = 2;
  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [31:0] KSQ_RST_CTRL = 32'h0000_0000;
  localparam logic [31:0] KSQ_RST_IREN = 32'h0000_0000;

  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } ksq_req_t;

  typedef struct packed {
    logic        valid;
    logic [31:0] addr;
  } ksq_cmd_t;

  typedef struct packed {
    logic        valid;
    logic [29:0] word_addr;
    logic        is_read;
  } ksq_fault_t;
endpackage

// [src/ksq_slot_mem.sv]
/*
  Two-entry address store for pending command records.
  Assumes the caller never writes a slot that is still pending.
*/
`timescale 1ns/1ps
`default_nettype none
module ksq_slot_mem (
  input  wire logic        clock,
  input  wire logic        we,
  input  wire logic        waddr,
  input  wire logic [31:0] wdata,
  input  wire logic        raddr,
  output var  logic [31:0] rdata
);
  logic [31:0] mem_ff [2];
  // No reset: stored addresses are undefined after reset
  always_ff @(posedge clock) begin
    if (we) begin
      mem_ff[waddr] <= wdata;
    end
    rdata <= mem_ff[raddr];
  end
endmodule
`default_nettype wire

// [src/ksq_top.sv]
/*
  Key-setup command queue: double-buffered command-record address
  register, full and done status, master fault capture, interrupt.
  Assumes a register port master that never issues read and write
  together, and an engine that handshakes one record at a time.
*/
// Design decision made here: strobed register access.
// Overview of operation
// R1: The fault register bit 1 tells whether the faulted master access was a read (1) or a write (0).
// R2: Writing a record address to the second command register starts key-setup of that record.
// R3: Software writes the second command register only while the full flag reads 0.
// R4: The address register is double-buffered so a second address queues and runs back to back.
// R5: Software does not write the second command register while bus mastering is disabled.
// R6: The second command register is read/write and has no defined reset value.
// R7: Status bit 27 reads 1 while the queue cannot take another address, resets to 0.
// R8: Status bit 26 is set sticky when a queued record completes and is cleared by writing 1.
// R9: On a master fault the faulting word address is captured in fault register bits 31:2.
// R10: Status bit 28 is set on a master access error and held until soft or hard reset.
// R11: With both slots pending the full flag stays 1 until the engine takes the oldest one.
`timescale 1ns/1ps
`default_nettype none
module ksq_top (
  input  wire logic                 clock,
  input  wire logic                 rst,
  input  wire ksq_pkg::ksq_req_t    req,
  output var  logic [31:0]          rdata,
  output var  ksq_pkg::ksq_cmd_t    cmd,
  input  wire logic                 cmd_take,
  input  wire logic                 cmd_done,
  input  wire ksq_pkg::ksq_fault_t  fault,
  output var  logic                 irq
);
  import ksq_pkg::*;

  typedef struct packed {
    logic [31:0] ctrl;
    logic [31:0] iren;
    logic        full;
    logic        done;
    logic        err;
    logic [29:0] flt_addr;
    logic        flt_rd;
    logic [1:0]  pend;
    logic        wp;
    logic        rp;
    logic [31:0] last_wr;
    logic [31:0] rdata;
    logic        cvalid;
    logic        irq;
    logic        rd_mem;
  } ksq_state_t;

  ksq_state_t st_ff, nxt_st;
  logic [31:0] mem_rdata;
  logic [31:0] status_w;
  logic        soft_rst;
  logic        cmd_wr;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    return a == off;
  endfunction

  assign soft_rst = st_ff.ctrl[KSQ_BIT_SOFT_RST];
  assign cmd_wr   = req.wr && hit(req.addr, KSQ_OFF_CMD2)
                    && st_ff.ctrl[KSQ_BIT_MASTER_EN];  // [R5]

  always_comb begin
    status_w = 32'h0000_0000;
    status_w[KSQ_BIT_ERR]  = st_ff.err;
    status_w[KSQ_BIT_FULL] = st_ff.full;  // [R7]
    status_w[KSQ_BIT_DONE] = st_ff.done;
  end

  // ----------------------------------------------------------------
  // Slot storage
  // ----------------------------------------------------------------
  ksq_slot_mem u_mem (
    .clock (clock),
    .we    (cmd_wr && !st_ff.pend[st_ff.wp]),  // [R3]
    .waddr (st_ff.wp),
    .wdata (req.wdata),
    .raddr (st_ff.rp),
    .rdata (mem_rdata)
  );

  always_comb begin
    logic [1:0] pend;
    logic       took;
    pend   = st_ff.pend;
    took   = 1'b0;
    nxt_st = st_ff;
    nxt_st.ctrl[KSQ_BIT_SOFT_RST] = 1'b0;
    // Engine takes oldest entry; two-cycle bubble while pointer moves and memory reads
    nxt_st.rd_mem = 1'b0;
    if (st_ff.cvalid && cmd_take) begin
      pend[st_ff.rp] = 1'b0;  // [R11]
      nxt_st.rp      = ~st_ff.rp;
      nxt_st.cvalid  = 1'b0;
      took           = 1'b1;
    end
    if (cmd_wr && !st_ff.pend[st_ff.wp]) begin
      pend[st_ff.wp] = 1'b1;  // [R2] [R4]
      nxt_st.wp      = ~st_ff.wp;
      nxt_st.last_wr = req.wdata;  // [R6]
    end
    if (!st_ff.cvalid && !took && !st_ff.rd_mem && st_ff.pend[st_ff.rp]) begin
      nxt_st.rd_mem = 1'b1;
    end
    if (st_ff.rd_mem) begin
      nxt_st.cvalid = 1'b1;  // [R2]
    end
    nxt_st.pend = pend;
    nxt_st.full = &pend;  // [R4] [R11]
    // ----------------------------------------------------------------
    // Status events: set wins over clear
    // ----------------------------------------------------------------
    if (req.wr && hit(req.addr, KSQ_OFF_STATUS) && req.wdata[KSQ_BIT_DONE]) begin
      nxt_st.done = 1'b0;
    end
    if (req.wr && hit(req.addr, KSQ_OFF_IRQ_CLR) && req.wdata[KSQ_BIT_DONE]) begin
      nxt_st.done = 1'b0;
    end
    if (cmd_done) begin
      nxt_st.done = 1'b1;  // [R8]
    end
    if (fault.valid) begin
      nxt_st.err      = 1'b1;  // [R10]
      nxt_st.flt_addr = fault.word_addr;  // [R9]
      nxt_st.flt_rd   = fault.is_read;  // [R1]
    end
    if (req.wr && hit(req.addr, KSQ_OFF_CTRL)) begin
      nxt_st.ctrl = req.wdata;
    end
    if (req.wr && hit(req.addr, KSQ_OFF_IRQ_EN)) begin
      nxt_st.iren = req.wdata;
    end
    nxt_st.rdata = 32'h0000_0000;
    if (req.rd) begin
      case (req.addr)
        KSQ_OFF_CTRL:   nxt_st.rdata = st_ff.ctrl;
        KSQ_OFF_STATUS: nxt_st.rdata = status_w;
        KSQ_OFF_FAULT:  nxt_st.rdata = {st_ff.flt_addr, st_ff.flt_rd, 1'b0};
        KSQ_OFF_CMD2:   nxt_st.rdata = st_ff.last_wr;  // [R6]
        KSQ_OFF_IRQ_EN: nxt_st.rdata = st_ff.iren;
        default:        nxt_st.rdata = 32'h0000_0000;
      endcase
    end
    nxt_st.irq = |(status_w & st_ff.iren);
    if (soft_rst) begin
      // Set wins: an event landing on the soft reset still shows
      nxt_st.err    = fault.valid;  // [R10]
      nxt_st.done   = cmd_done;  // [R8]
      nxt_st.pend   = 2'b00;
      nxt_st.full   = 1'b0;
      nxt_st.wp     = 1'b0;
      nxt_st.rp     = 1'b0;
      nxt_st.cvalid = 1'b0;
      nxt_st.rd_mem = 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      st_ff.ctrl    <= KSQ_RST_CTRL;
      st_ff.iren    <= KSQ_RST_IREN;
      st_ff.full    <= 1'b0;
      st_ff.done    <= 1'b0;
      st_ff.err     <= 1'b0;
      st_ff.pend    <= 2'b00;
      st_ff.wp      <= 1'b0;
      st_ff.rp      <= 1'b0;
      st_ff.rdata   <= 32'h0000_0000;
      st_ff.cvalid  <= 1'b0;
      st_ff.irq     <= 1'b0;
      st_ff.rd_mem  <= 1'b0;
      st_ff.flt_addr <= nxt_st.flt_addr;
      st_ff.flt_rd   <= nxt_st.flt_rd;
      st_ff.last_wr  <= nxt_st.last_wr;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Command output: address held in the slot memory's read register
  always_comb begin
    cmd.valid = st_ff.cvalid;
    cmd.addr  = mem_rdata;
  end
  assign rdata = st_ff.rdata;
  assign irq   = st_ff.irq;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  AST_FULL_BOTH: assert property (@(posedge clock) disable iff (rst)  // [R11]
    st_ff.full && !soft_rst && !(st_ff.cvalid && cmd_take) |=> st_ff.full)
    else $error("full flag dropped before take");
  AST_FULL_STATUS: assert property (@(posedge clock) disable iff (rst)  // [R7]
    req.rd && req.addr == KSQ_OFF_STATUS |=> rdata[KSQ_BIT_FULL] == $past(st_ff.full))
    else $error("full flag not read back");
  AST_DONE_SET: assert property (@(posedge clock) disable iff (rst)  // [R8]
    cmd_done && !soft_rst |=> st_ff.done) else $error("done not set");
  AST_ERR_HOLD: assert property (@(posedge clock) disable iff (rst)  // [R10]
    st_ff.err && !soft_rst |=> st_ff.err) else $error("error flag dropped");
  AST_ERR_SET: assert property (@(posedge clock) disable iff (rst)  // [R10]
    fault.valid |=> st_ff.err) else $error("error not set");
  AST_FLT_ADDR: assert property (@(posedge clock) disable iff (rst)  // [R9]
    fault.valid |=> st_ff.flt_addr == $past(fault.word_addr)) else $error("fault addr");
  AST_FLT_RD: assert property (@(posedge clock) disable iff (rst)  // [R1]
    fault.valid |=> st_ff.flt_rd == $past(fault.is_read)) else $error("fault dir");
  AST_START: assert property (@(posedge clock) disable iff (rst)  // [R2]
    cmd_wr && st_ff.pend == 2'b00 && !st_ff.cvalid && !soft_rst |-> ##3 cmd.valid)
    else $error("record not started");
  AST_CMD_RB: assert property (@(posedge clock) disable iff (rst)  // [R6]
    cmd_wr && !st_ff.pend[st_ff.wp] ##1 req.rd && req.addr == KSQ_OFF_CMD2
    |=> rdata == $past(req.wdata, 2)) else $error("cmd reg readback");
  AST_SECOND: assert property (@(posedge clock) disable iff (rst)  // [R4]
    st_ff.pend == 2'b01 && !soft_rst && !(st_ff.cvalid && cmd_take)
    |=> st_ff.full == $past(cmd_wr))
    else $error("full flag wrong with one slot pending");
endmodule
`default_nettype wire
